// >>> hw/limit_compare_regs.vh
// register offsets, field positions and reset values for the limit threshold bank
// assumes the includer is a plain verilog-2005 module on one 250 mhz clock
//
// Summary of operation
// - trim_checksum_ok drops to 0 on checksum error
// - negative shunt over limit trips at zero
// - signed 16-bit shunt over limit, reset 7fff
// - shunt limits share shunt result step size
// - signed 16-bit shunt under limit, reset 8000
// - 15-bit bus over limit, reset 7fff
// - 15-bit bus under limit, reset zero
// - bus limit bit 15 reads zero
// - signed 12-bit heat ceiling in bits 15-4
// - heat ceiling bits 3-0 read zero
// - 16-bit power ceiling, reset ffff, 256 steps
// - shunt over and under flags set
// - bus over and under flags set
// - heat and power over flags set
// - transparent flags follow, latched clear on read
`ifndef LIMIT_COMPARE_REGS_VH
`define LIMIT_COMPARE_REGS_VH

// =====================================================
// register indices
`define ADDR_DIAG 8'h0b
`define ADDR_SHUNT_OVER 8'h0c
`define ADDR_SHUNT_UNDER 8'h0d
`define ADDR_BUS_OVER 8'h0e
`define ADDR_BUS_UNDER 8'h0f
`define ADDR_HEAT_CEIL 8'h10
`define ADDR_POWER_CEIL 8'h11
`define NUM_REGS 6

// =====================================================
// reset values
`define RST_SHUNT_OVER 16'h7fff
`define RST_SHUNT_UNDER 16'h8000
`define RST_BUS_OVER 16'h7fff
`define RST_BUS_UNDER 16'h0000
`define RST_HEAT_CEIL 16'h7fff
`define RST_POWER_CEIL 16'hffff

// =====================================================
// field positions and masks
`define BUS_FIELD_MASK 16'h7fff
`define HEAT_FIELD_MASK 16'hfff0
`define DIAG_LATCH_BIT 15
`define DIAG_HEAT_BIT 7
`define DIAG_SHUNT_OVER_BIT 6
`define DIAG_SHUNT_UNDER_BIT 5
`define DIAG_BUS_OVER_BIT 4
`define DIAG_BUS_UNDER_BIT 3
`define DIAG_POWER_BIT 2
`define DIAG_MEM_BIT 0

`endif

// >>> hw/limit_reg_store.v
// six-entry 16-bit store for the threshold registers, read data registered
// assumes writes and reads come from the limit compare top on the same clock
`timescale 1ns/1ps
`include "limit_compare_regs.vh"

module limit_reg_store (
    clk,
    rst_b,
    wr_en,
    wr_idx,
    wr_data,
    rd_idx,
    rd_data,
    flat_q
);
    input wire clk;
    input wire rst_b;
    input wire wr_en;
    input wire [2:0] wr_idx;
    input wire [15:0] wr_data;
    input wire [2:0] rd_idx;
    output reg [15:0] rd_data;
    output wire [16*`NUM_REGS-1:0] flat_q;

    // =====================================================
    // storage, held in flops so every limit feeds a comparator at once
    localparam [16*`NUM_REGS-1:0] rst_flat = {`RST_POWER_CEIL, `RST_HEAT_CEIL, `RST_BUS_UNDER, `RST_BUS_OVER,
                                              `RST_SHUNT_UNDER, `RST_SHUNT_OVER};
    // reserved bits never store, so they read zero, from reset on as well
    localparam [16*`NUM_REGS-1:0] mask_flat = {16'hffff, `HEAT_FIELD_MASK, `BUS_FIELD_MASK, `BUS_FIELD_MASK,
                                               16'hffff, 16'hffff};

    genvar i;
    generate
        for (i = 0; i < `NUM_REGS; i = i + 1) begin : g_ent
            reg [15:0] ent_q;
            always @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    ent_q <= rst_flat[16*i+15:16*i] & mask_flat[16*i+15:16*i];
                end else if (wr_en && wr_idx == i) begin
                    ent_q <= wr_data & mask_flat[16*i+15:16*i];
                end
            end
            assign flat_q[16*i+15:16*i] = ent_q;
        end
    endgenerate

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            rd_data <= 16'h0000;
        end else if (rd_idx < `NUM_REGS) begin
            rd_data <= flat_q[{rd_idx, 4'h0} +: 16];
        end else begin
            rd_data <= 16'h0000;
        end
    end
endmodule

// >>> hw/limit_threshold_compare.v
// limit threshold bank with diagnostic flag logic
// assumes the serial host front end delivers one-cycle reg_wr/reg_rd strobes
// and that measurement results arrive with a one-cycle result_valid pulse on clk
`timescale 1ns/1ps
`include "limit_compare_regs.vh"

module limit_threshold_compare (
    clk,
    rst_b,
    reg_addr,
    reg_wr,
    reg_rd,
    reg_wdata,
    reg_rdata,
    reg_rvalid,
    result_valid,
    shunt_result,
    bus_result,
    die_heat_result,
    power_result,
    shunt_range_select,
    checksum_err,
    diag_flags,
    diag_flags_reg_q
);
    input wire clk;
    input wire rst_b;
    input wire [7:0] reg_addr;
    input wire reg_wr;
    input wire reg_rd;
    input wire [15:0] reg_wdata;
    output reg [15:0] reg_rdata;
    output reg reg_rvalid;
    input wire result_valid;
    input wire [15:0] shunt_result;
    input wire [15:0] bus_result;
    input wire [11:0] die_heat_result;
    input wire [23:0] power_result;
    input wire shunt_range_select;
    input wire checksum_err;
    output reg [6:0] diag_flags;
    output wire [15:0] diag_flags_reg_q;

    // =====================================================
    // decode
    wire [7:0] rel_addr;
    wire in_bank;
    wire [2:0] bank_idx;
    wire diag_hit;
    reg diag_rd_q;
    reg bank_rd_q;
    reg rd_q;

    assign rel_addr = reg_addr - `ADDR_SHUNT_OVER;
    assign in_bank = (reg_addr >= `ADDR_SHUNT_OVER) && (reg_addr <= `ADDR_POWER_CEIL);
    assign bank_idx = rel_addr[2:0];
    assign diag_hit = (reg_addr == `ADDR_DIAG);

    wire [16*`NUM_REGS-1:0] flat_q;
    wire [15:0] store_rdata;

    limit_reg_store u_store (
        .clk(clk),
        .rst_b(rst_b),
        .wr_en(reg_wr && in_bank),
        .wr_idx(bank_idx),
        .wr_data(reg_wdata),
        .rd_idx(bank_idx),
        .rd_data(store_rdata),
        .flat_q(flat_q)
    );

    wire [15:0] shunt_over_threshold;
    wire [15:0] shunt_under_threshold;
    wire [15:0] bus_over_threshold;
    wire [15:0] bus_under_threshold;
    wire [15:0] die_heat_ceiling;
    wire [15:0] power_ceiling;
    wire [11:0] heat_ceiling_field;

    assign shunt_over_threshold = flat_q[15:0];
    assign shunt_under_threshold = flat_q[31:16];
    assign bus_over_threshold = flat_q[47:32];
    assign bus_under_threshold = flat_q[63:48];
    assign die_heat_ceiling = flat_q[79:64];
    assign power_ceiling = flat_q[95:80];
    assign heat_ceiling_field = die_heat_ceiling[15:4];

    // =====================================================
    // comparisons; the range select only rescales the lsb, and limits share that
    // scale with the result, so the raw codes compare directly
    wire shunt_over_hit;
    wire shunt_under_hit;
    wire bus_over_hit;
    wire bus_under_hit;
    wire heat_over_hit;
    wire power_over_hit;

    // signed compare: a negative limit is already exceeded by a zero result
    assign shunt_over_hit = $signed(shunt_result) > $signed(shunt_over_threshold);
    assign shunt_under_hit = $signed(shunt_result) < $signed(shunt_under_threshold);
    assign bus_over_hit = {1'b0, bus_result[14:0]} > (bus_over_threshold & `BUS_FIELD_MASK);
    assign bus_under_hit = {1'b0, bus_result[14:0]} < (bus_under_threshold & `BUS_FIELD_MASK);
    assign heat_over_hit = $signed(die_heat_result) > $signed(heat_ceiling_field);
    // limit lsb is 256 power steps, so drop the low byte of the result
    assign power_over_hit = power_result[23:8] > power_ceiling;

    // =====================================================
    // diagnostic flags
    reg flag_latch_select_q;
    reg trim_checksum_ok_q;
    reg heat_over_flag_q;
    reg shunt_over_flag_q;
    reg shunt_under_flag_q;
    reg bus_over_flag_q;
    reg bus_under_flag_q;
    reg power_over_flag_q;
    wire diag_read;
    wire [5:0] hit_vec;
    wire [5:0] flag_vec;
    reg [5:0] flag_d;

    assign diag_read = reg_rd && diag_hit;
    assign hit_vec = {heat_over_hit, shunt_over_hit, shunt_under_hit,
                      bus_over_hit, bus_under_hit, power_over_hit};
    assign flag_vec = {heat_over_flag_q, shunt_over_flag_q, shunt_under_flag_q,
                       bus_over_flag_q, bus_under_flag_q, power_over_flag_q};

    always @* begin
        flag_d = flag_vec;
        if (result_valid) begin
            if (flag_latch_select_q) begin
                // a new hit in the read cycle wins over the read clear
                flag_d = (diag_read ? 6'h00 : flag_vec) | hit_vec;
            end else begin
                flag_d = hit_vec;
            end
        end else if (flag_latch_select_q && diag_read) begin
            flag_d = 6'h00;
        end
    end

    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            flag_latch_select_q <= 1'b0;
            trim_checksum_ok_q <= 1'b1;
            heat_over_flag_q <= 1'b0;
            shunt_over_flag_q <= 1'b0;
            shunt_under_flag_q <= 1'b0;
            bus_over_flag_q <= 1'b0;
            bus_under_flag_q <= 1'b0;
            power_over_flag_q <= 1'b0;
        end else begin
            if (reg_wr && diag_hit) begin
                flag_latch_select_q <= reg_wdata[`DIAG_LATCH_BIT];
            end
            // sticky low: once the trim check fails only a reset restores it
            if (checksum_err) begin
                trim_checksum_ok_q <= 1'b0;
            end
            heat_over_flag_q <= flag_d[5];
            shunt_over_flag_q <= flag_d[4];
            shunt_under_flag_q <= flag_d[3];
            bus_over_flag_q <= flag_d[2];
            bus_under_flag_q <= flag_d[1];
            power_over_flag_q <= flag_d[0];
        end
    end

    assign diag_flags_reg_q = {flag_latch_select_q, 7'h00, flag_vec, 1'b0, trim_checksum_ok_q};

    // =====================================================
    // read return: the strobe edge captures, the next edge loads the output flop,
    // so reg_rvalid and reg_rdata stand one edge after the strobe edge
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            diag_rd_q <= 1'b0;
            bank_rd_q <= 1'b0;
            rd_q <= 1'b0;
            reg_rvalid <= 1'b0;
            diag_flags <= 7'h01;
        end else begin
            diag_rd_q <= diag_read;
            bank_rd_q <= reg_rd && in_bank;
            rd_q <= reg_rd;
            reg_rvalid <= rd_q;
            diag_flags <= {flag_vec, trim_checksum_ok_q};
        end
    end

    // diag snapshot taken in the strobe cycle, before the latched clear lands
    reg [15:0] diag_snap_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            diag_snap_q <= 16'h0001;
        end else begin
            diag_snap_q <= diag_flags_reg_q;
        end
    end

    // one extra cycle of latency buys a read port driven straight from a flop
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            reg_rdata <= 16'h0000;
        end else if (diag_rd_q) begin
            reg_rdata <= diag_snap_q;
        end else if (bank_rd_q) begin
            reg_rdata <= store_rdata;
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule

// >>> testbench/limit_host_model.sv
// host side of the register strobes, one request per call
// assumes the bench calls xfer; all signals move on falling edges
`timescale 1ns/1ps
module limit_host_model (
    input wire clk,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire reg_rvalid
);
    // ==========
    // idle state
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 16'h0000;
    end
    // ==========
    // one strobe; released lines show the inverse so stale values never pass
    task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d, output logic [15:0] q);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = w;
        reg_rd = !w;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = ~a;
        reg_wdata = ~d;
        // read data and its valid stand one edge after the strobe edge
        @(negedge clk);
        q = (reg_rvalid === 1'b1) ? reg_rdata : 16'hxxxx;
    endtask
endmodule

// >>> testbench/limit_threshold_compare_chk.sv
// assertions on the limit bank top ports
// assumes one clock, rst_b async low; shadows follow host writes
`timescale 1ns/1ps
`include "limit_compare_regs.vh"
module limit_threshold_compare_chk (
    input wire clk,
    input wire rst_b,
    input wire [7:0] reg_addr,
    input wire reg_wr,
    input wire reg_rd,
    input wire [15:0] reg_wdata,
    input wire [15:0] reg_rdata,
    input wire reg_rvalid,
    input wire result_valid,
    input wire [15:0] shunt_result,
    input wire [23:0] power_result,
    input wire checksum_err,
    input wire [15:0] diag_flags_reg_q
);
    // ==========
    // shadow limits, only the two whose compare is checked here
    logic [15:0] so_q;
    logic [15:0] pw_q;
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            so_q <= 16'h7fff;
            pw_q <= 16'hffff;
        end else if (reg_wr) begin
            if (reg_addr == `ADDR_SHUNT_OVER) so_q <= reg_wdata;
            if (reg_addr == `ADDR_POWER_CEIL) pw_q <= reg_wdata;
        end
    end
    wire lat = diag_flags_reg_q[15];
    wire so_hit = $signed(shunt_result) > $signed(so_q);
    wire pw_hit = power_result[23:8] > pw_q;
    sequence s_rd(a);
        reg_rd && reg_addr == a;
    endsequence
    // ==========
    // properties
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);
    property p_trim_drop; checksum_err |=> !diag_flags_reg_q[0]; endproperty
    a_trim_drop: assert property (p_trim_drop) else $error("trim bit kept");
    property p_trim_keep; !diag_flags_reg_q[0] |=> !diag_flags_reg_q[0]; endproperty
    a_trim_keep: assert property (p_trim_keep) else $error("trim bit came back");
    property p_so; result_valid && !lat |=> diag_flags_reg_q[6] == $past(so_hit); endproperty
    a_so: assert property (p_so) else $error("shunt over flag wrong");
    property p_pw; result_valid && !lat |=> diag_flags_reg_q[2] == $past(pw_hit); endproperty
    a_pw: assert property (p_pw) else $error("power flag wrong");
    property p_bus_rd; s_rd(`ADDR_BUS_OVER) or s_rd(`ADDR_BUS_UNDER) |=> ##1 reg_rvalid && !reg_rdata[15]; endproperty
    a_bus_rd: assert property (p_bus_rd) else $error("bus limit top bit set");
    property p_heat_rd; s_rd(`ADDR_HEAT_CEIL) |=> ##1 reg_rvalid && reg_rdata[3:0] == 4'h0; endproperty
    a_heat_rd: assert property (p_heat_rd) else $error("heat low bits set");
    property p_hold; lat && diag_flags_reg_q[6] && !reg_rd && !reg_wr |=> diag_flags_reg_q[6]; endproperty
    a_hold: assert property (p_hold) else $error("latched flag dropped");
    property p_clr; lat && !result_valid ##0 s_rd(`ADDR_DIAG) |=> !diag_flags_reg_q[6]; endproperty
    a_clr: assert property (p_clr) else $error("latched flag not cleared");
endmodule
bind limit_threshold_compare limit_threshold_compare_chk chk (
    .clk(clk),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid),
    .result_valid(result_valid),
    .shunt_result(shunt_result),
    .power_result(power_result),
    .checksum_err(checksum_err),
    .diag_flags_reg_q(diag_flags_reg_q)
);

// >>> testbench/limit_threshold_compare_test.sv
// self-checking bench for the limit threshold bank
// assumes the host model makes register strobes; this bench drives results
`timescale 1ns/1ps
`include "limit_compare_regs.vh"
module limit_threshold_compare_test;
    logic clk, rst_b, result_valid, shunt_range_select, checksum_err, reg_wr, reg_rd, reg_rvalid;
    logic [7:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, shunt_result, bus_result, diag_flags_reg_q, q;
    logic [11:0] die_heat_result;
    logic [23:0] power_result;
    logic [6:0] diag_flags;
    int fails, num_checks, cyc;
    logic [15:0] rv [6] = '{16'h7fff, 16'h8000, 16'h7fff, 16'h0000, 16'h7ff0, 16'hffff};
    logic [39:0] regs [8] = '{{`ADDR_SHUNT_OVER, 16'h0100, 16'h0100}, {`ADDR_SHUNT_UNDER, 16'hff00, 16'hff00},
        {`ADDR_BUS_OVER, 16'h9000, 16'h1000}, {`ADDR_BUS_UNDER, 16'h8800, 16'h0800},
        {`ADDR_HEAT_CEIL, 16'h320f, 16'h3200}, {`ADDR_POWER_CEIL, 16'h0100, 16'h0100},
        {8'h20, 16'h1234, 16'h0000}, {`ADDR_DIAG, 16'h0000, 16'h0001}};
    logic [73:0] runs [4] = '{{16'h0101, 16'h1001, 12'h321, 24'h010100, 6'b110101},
        {16'hfeff, 16'h07ff, 12'h31f, 24'h000000, 6'b001010},
        {16'h0100, 16'h0800, 12'h320, 24'h0100ff, 6'b000000},
        {16'h0000, 16'h8900, 12'h000, 24'h000000, 6'b000000}};
    limit_threshold_compare dut (
        .clk(clk),
        .rst_b(rst_b),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .result_valid(result_valid),
        .shunt_result(shunt_result),
        .bus_result(bus_result),
        .die_heat_result(die_heat_result),
        .power_result(power_result),
        .shunt_range_select(shunt_range_select),
        .checksum_err(checksum_err),
        .diag_flags(diag_flags),
        .diag_flags_reg_q(diag_flags_reg_q)
    );
    limit_host_model host (
        .clk(clk),
        .reg_addr(reg_addr),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid)
    );
    // ==========
    // helpers
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic meas(input logic [15:0] s, input logic [15:0] b, input logic [11:0] h, input logic [23:0] p);
        @(negedge clk);
        {shunt_result, bus_result, die_heat_result, power_result} = {s, b, h, p};
        result_valid = 1'b1;
        @(negedge clk);
        result_valid = 1'b0;
    endtask
    task automatic report_and_stop;
        $display("checks %0d fails %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // ==========
    // clock and hang guard; whole run is about 110 cycles
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (cyc == 2000) begin
            fails++;
            report_and_stop;
        end
    end
    // ==========
    // tests
    initial begin
        {rst_b, result_valid, shunt_range_select, checksum_err} = 4'h0;
        {shunt_result, bus_result, die_heat_result, power_result} = '0;
        repeat (3) @(negedge clk);
        rst_b = 1'b1;
        chk(diag_flags_reg_q, 16'h0001);
        for (int i = 0; i < 6; i++) begin
            host.xfer(0, 8'h0c + 8'(i), 16'h0000, q);
            chk(q, rv[i]);
        end
        $display("reset test done");
        foreach (regs[i]) begin
            host.xfer(1, regs[i][39:32], regs[i][31:16], q);
            host.xfer(0, regs[i][39:32], 16'h0000, q);
            chk(q, regs[i][15:0]);
        end
        foreach (runs[i]) begin
            meas(runs[i][73:58], runs[i][57:42], runs[i][41:30], runs[i][29:6]);
            chk(diag_flags_reg_q, {8'h00, runs[i][5:0], 2'b01});
            @(negedge clk);
            chk({9'h000, diag_flags}, {9'h000, runs[i][5:0], 1'b1});
        end
        $display("flag table done");
        host.xfer(1, `ADDR_SHUNT_UNDER, 16'hfff0, q);
        host.xfer(1, `ADDR_SHUNT_OVER, 16'hfffe, q);
        shunt_range_select = 1'b1;
        meas(16'h0000, 16'h0900, 12'h000, 24'h0);
        chk(diag_flags_reg_q, 16'h0041);
        host.xfer(1, `ADDR_DIAG, 16'h8000, q);
        meas(16'h0000, 16'h0900, 12'h000, 24'h0);
        meas(16'hfff8, 16'h0900, 12'h000, 24'h0);
        chk(diag_flags_reg_q, 16'h8041);
        host.xfer(0, `ADDR_DIAG, 16'h0000, q);
        chk(q, 16'h8041);
        chk(diag_flags_reg_q, 16'h8001);
        // a hit in the same cycle as the read: the set wins, the read shows the old image
        fork
            host.xfer(0, `ADDR_DIAG, 16'h0000, q);
            meas(16'h0000, 16'h0900, 12'h000, 24'h0);
        join
        chk(q, 16'h8001);
        chk(diag_flags_reg_q, 16'h8041);
        $display("latch test done");
        checksum_err = 1'b1;
        @(negedge clk);
        checksum_err = 1'b0;
        repeat (2) @(negedge clk);
        chk(diag_flags_reg_q, 16'h8040);
        $display("trim test done");
        rst_b = 1'b0;
        @(negedge clk);
        rst_b = 1'b1;
        chk(diag_flags_reg_q, 16'h0001);
        chk({9'h000, diag_flags}, 16'h0001);
        host.xfer(0, `ADDR_HEAT_CEIL, 16'h0000, q);
        chk(q, 16'h7ff0);
        $display("mid reset test done");
        report_and_stop;
    end
endmodule
